//--- src/sdbx_core.sv
/*
 * Executes four-wide and homogeneous dot products and the else and end-if
 * conditional-block controls of one SIMD thread.
 * Assumes instruction fetch, thread control and register file run on the
 * same clock, so their inputs are read without synchronisers; the source
 * operands arrive already swizzled, one 32-bit float per channel.
 */
// Added by the designer: the strobed register port and the placing of the registers.
// Function
// - Four-wide dot replicated into each channel group
// - Write only channels whose write mask is set
// - Homogeneous dot forces first source fourth element one
// - Accumulator destination uses same group replication
// - Else swaps if-portion channels for the opposite set
// - Channels inactive on entry stay inactive
// - Else jumps when every channel redirected
// - Offset in 64-bit chunks added pre-increment
// - Offset bits 15:0 signed, upper bits zero
// - Else offset from destination field
// - End-if offset from second source field
// - Single program flow freezes per-channel pointers
// - End-if re-enables channels active before block
// - End-if jumps outward when no channel enabled
// - End-if ignores execution width
module sdbx_core
	import sdbx_pkg::*;
#(
	parameter int NCH = 8,  // Channels of the thread.
	parameter int IPW = 32  // Instruction pointer width, at least 16.
) (
	input  wire logic                 CORE_CLK_I,        // Core clock, 40 MHz.
	input  wire logic                 RESETN_I,          // Synchronous reset, low.
	input  wire logic [REG_AW-1:0]    REG_ADDR_I,        // Register byte address.
	input  wire logic [31:0]          REG_WDATA_I,       // Register write data.
	input  wire logic                 REG_WR_I,          // Register write strobe.
	input  wire logic                 REG_RD_I,          // Register read strobe.
	output logic      [31:0]          REG_RDATA_O,       // Read data, next cycle.
	input  wire logic                 THREAD_START_I,    // Load thread pointers.
	input  wire logic [NCH-1:0]       DISPATCH_MASK_I,   // Channels dispatched.
	input  wire logic                 INSTR_VALID_I,     // Instruction present.
	input  wire logic [6:0]           OPCODE_I,          // Instruction opcode.
	input  wire logic [IPW-1:0]       INSTR_IP_I,        // Pointer of instruction.
	input  wire logic [$clog2(NCH):0] EXEC_SIZE_I,       // Execution width.
	input  wire logic [31:0]          DST_FIELD_I,       // Destination operand.
	input  wire logic [31:0]          SRC1_FIELD_I,      // Second source operand.
	input  wire logic                 DST_IS_ACC_I,      // Destination is accumulator.
	input  wire logic [NCH-1:0]       WRITE_MASK_I,      // Evaluated write mask.
	input  wire logic [NCH*32-1:0]    SRC0_DATA_I,       // First source channels.
	input  wire logic [NCH*32-1:0]    SRC1_DATA_I,       // Second source channels.
	output logic                      BUSY_O,            // Dot product running.
	output logic                      RESULT_VALID_O,    // Dot result pulse.
	output logic      [NCH-1:0]       DST_WE_O,          // Register channel writes.
	output logic      [NCH-1:0]       ACC_WE_O,          // Accumulator writes.
	output logic      [NCH*32-1:0]    DST_DATA_O,        // Result channels.
	output logic                      NEXT_IP_VALID_O,   // Branch resolved pulse.
	output logic                      JUMP_TAKEN_O,      // Branch jumped.
	output logic      [IPW-1:0]       NEXT_IP_O,         // Next pointer.
	output logic      [NCH-1:0]       CHANNEL_EN_O       // Channels enabled.
);

	localparam int CW = $clog2(NCH);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [IPW-1:0] jump_target(input logic [IPW-1:0] ip,
	                                               input logic [31:0]    field);
		jump_target = ip + IPW'($signed(field[JIP_W-1:0]));
	endfunction : jump_target

	function automatic logic [NCH-1:0] in_width(input logic [CW:0] esz);
		for (int n = 0; n < NCH; n++) begin
			in_width[n] = (n < esz);
		end
	endfunction : in_width

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	sdbx_state_t       state;
	sdbx_state_t       next_state;
	logic [CW-1:0]     k;
	logic [CW-1:0]     next_k;
	logic [31:0]       acc;
	logic [31:0]       next_acc;
	logic [NCH*32-1:0] s0;
	logic [NCH*32-1:0] next_s0;
	logic [NCH*32-1:0] s1;
	logic [NCH*32-1:0] next_s1;
	logic [NCH*32-1:0] res;
	logic [NCH*32-1:0] next_res;
	logic [NCH-1:0]    wmask;
	logic [NCH-1:0]    next_wmask;
	logic [CW:0]       esz;
	logic [CW:0]       next_esz;
	logic              homog;
	logic              next_homog;
	logic              to_acc;
	logic              next_to_acc;
	logic              next_busy;
	logic              next_rvalid;
	logic [NCH-1:0]    next_dst_we;
	logic [NCH-1:0]    next_acc_we;
	logic [NCH*32-1:0] next_dout;

	logic [IPW-1:0]    per_channel_ip      [NCH];
	logic [IPW-1:0]    next_per_channel_ip [NCH];
	logic [NCH-1:0]    live;
	logic [NCH-1:0]    next_live;
	logic              single_program_flow_flag;
	logic              next_spf;
	logic              next_nip_valid;
	logic              next_jump;
	logic [IPW-1:0]    next_nip;
	logic [NCH-1:0]    next_chan_en;
	logic [31:0]       next_rdata;

	sdbx_fma_if fma_bus ();

	sdbx_fma u_fma (
		.bus (fma_bus)
	);

	// ------------------------------------------------------------------
	// Dot product sequencer
	// ------------------------------------------------------------------
	// One channel per cycle; the running sum restarts at each group.
	assign fma_bus.a = (homog && k[1:0] == 2'b11) ? FP_ONE : s0[{k, 5'h00} +: 32];
	assign fma_bus.b = s1[{k, 5'h00} +: 32];
	assign fma_bus.c = (k[1:0] == 2'b00) ? FP_ZERO : acc;

	always_comb begin
		next_state  = state;
		next_k      = k;
		next_acc    = acc;
		next_s0     = s0;
		next_s1     = s1;
		next_res    = res;
		next_wmask  = wmask;
		next_esz    = esz;
		next_homog  = homog;
		next_to_acc = to_acc;
		next_rvalid = 1'b0;
		next_dst_we = '0;
		next_acc_we = '0;
		next_dout   = DST_DATA_O;
		unique case (state)
			ST_IDLE: begin
				if (INSTR_VALID_I &&
				    (OPCODE_I == OPC_FOUR_WIDE_DOT || OPCODE_I == OPC_HOMOG_DOT)) begin
					// Float operands, no accumulator source, width of four or
					// more and unit stride are guaranteed by the issuer.
					next_s0     = SRC0_DATA_I;
					next_s1     = SRC1_DATA_I;
					next_wmask  = WRITE_MASK_I;
					next_esz    = EXEC_SIZE_I;
					next_homog  = (OPCODE_I == OPC_HOMOG_DOT);
					next_to_acc = DST_IS_ACC_I;
					next_k      = '0;
					next_res    = res;
					next_state  = ST_DOT;
				end
			end
			ST_DOT: begin
				next_acc = fma_bus.r;
				if (k[1:0] == 2'b11) begin
					next_res[{k & ~CW'(3), 5'h00} +: 128] = {4{fma_bus.r}};
				end
				if ({1'b0, k} == esz - 1'b1) begin
					next_state  = ST_IDLE;
					next_rvalid = 1'b1;
					next_dout   = next_res;
					if (to_acc) begin
						next_acc_we = wmask & in_width(esz);
					end else begin
						next_dst_we = wmask & in_width(esz);
					end
				end else begin
					next_k = k + 1'b1;
				end
			end
		endcase
		next_busy = (next_state == ST_DOT);
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			state          <= ST_IDLE;
			k              <= '0;
			acc            <= FP_ZERO;
			s0             <= '0;
			s1             <= '0;
			res            <= '0;
			wmask          <= '0;
			esz            <= '0;
			homog          <= 1'b0;
			to_acc         <= 1'b0;
			BUSY_O         <= 1'b0;
			RESULT_VALID_O <= 1'b0;
			DST_WE_O       <= '0;
			ACC_WE_O       <= '0;
			DST_DATA_O     <= '0;
		end else begin
			state          <= next_state;
			k              <= next_k;
			acc            <= next_acc;
			s0             <= next_s0;
			s1             <= next_s1;
			res            <= next_res;
			wmask          <= next_wmask;
			esz            <= next_esz;
			homog          <= next_homog;
			to_acc         <= next_to_acc;
			BUSY_O         <= next_busy;
			RESULT_VALID_O <= next_rvalid;
			DST_WE_O       <= next_dst_we;
			ACC_WE_O       <= next_acc_we;
			DST_DATA_O     <= next_dout;
		end
	end

	// ------------------------------------------------------------------
	// Conditional-block flow and registers
	// ------------------------------------------------------------------
	// Outside single program flow a channel is enabled when it is live and its
	// pointer equals the next instruction pointer, and channels parked elsewhere wait;
	// under single program flow every live channel is enabled.
	always_comb begin
		logic [NCH-1:0] active;
		logic [NCH-1:0] pending;
		logic [IPW-1:0] ip_inc;
		logic [NCH-1:0] width_ok;
		width_ok       = in_width(EXEC_SIZE_I);
		active         = '0;
		pending        = '0;
		ip_inc         = INSTR_IP_I + IPW'(IP_STEP);
		next_per_channel_ip      = per_channel_ip;
		next_live      = live;
		next_spf       = single_program_flow_flag;
		next_nip_valid = 1'b0;
		next_jump      = 1'b0;
		next_nip       = NEXT_IP_O;
		next_chan_en   = CHANNEL_EN_O;
		next_rdata     = 32'h0000_0000;
		for (int n = 0; n < NCH; n++) begin
			active[n] = live[n] && (per_channel_ip[n] == INSTR_IP_I);
		end
		if (THREAD_START_I) begin
			next_live    = DISPATCH_MASK_I;
			next_chan_en = DISPATCH_MASK_I;
			for (int n = 0; n < NCH; n++) begin
				next_per_channel_ip[n] = INSTR_IP_I;
			end
		end else if (INSTR_VALID_I && state == ST_IDLE && OPCODE_I == OPC_ELSE) begin
			// Predication is never applied, so every active in-width channel acts outside single program flow.
			next_nip_valid = 1'b1;
			if (!single_program_flow_flag) begin
				for (int n = 0; n < NCH; n++) begin
					if (active[n] && width_ok[n]) begin
						next_per_channel_ip[n] = jump_target(INSTR_IP_I, DST_FIELD_I);
					end
				end
				for (int n = 0; n < NCH; n++) begin
					// Only channels parked at the else portion wake; those
					// parked past the block stay off.
					pending[n] = live[n] && (next_per_channel_ip[n] == ip_inc);
				end
			end
			next_jump = (pending == '0);
			next_nip  = next_jump ? jump_target(INSTR_IP_I, DST_FIELD_I) : ip_inc;
		end else if (INSTR_VALID_I && state == ST_IDLE && OPCODE_I == OPC_ENDIF) begin
			// Width is not consulted; accumulator operands never occur.
			next_nip_valid = 1'b1;
			pending        = single_program_flow_flag ? live : active;
			if (!single_program_flow_flag) begin
				// Channels parked here rejoin and step past the end-if.
				for (int n = 0; n < NCH; n++) begin
					if (active[n]) begin
						next_per_channel_ip[n] = ip_inc;
					end
				end
			end
			next_jump      = (pending == '0);
			next_nip       = next_jump ? jump_target(INSTR_IP_I, SRC1_FIELD_I) : ip_inc;
		end
		if (next_nip_valid) begin
			for (int n = 0; n < NCH; n++) begin
				next_chan_en[n] = next_live[n] &&
				                  (single_program_flow_flag || next_per_channel_ip[n] == next_nip);
			end
		end
		if (REG_WR_I && REG_ADDR_I == REG_FLOW_CTRL) begin
			next_spf = REG_WDATA_I[SPF_BIT];
		end
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				REG_FLOW_CTRL: next_rdata[SPF_BIT] = single_program_flow_flag;
				REG_CHAN_EN:   next_rdata[NCH-1:0] = CHANNEL_EN_O;
				REG_NEXT_IP:   next_rdata[IPW-1:0] = NEXT_IP_O;
				default:       next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			for (int n = 0; n < NCH; n++) begin
				per_channel_ip[n] <= '0;
			end
			live            <= '0;
			single_program_flow_flag             <= SPF_RESET;
			NEXT_IP_VALID_O <= 1'b0;
			JUMP_TAKEN_O    <= 1'b0;
			NEXT_IP_O       <= '0;
			CHANNEL_EN_O    <= '0;
			REG_RDATA_O     <= 32'h0000_0000;
		end else begin
			per_channel_ip            <= next_per_channel_ip;
			live            <= next_live;
			single_program_flow_flag             <= next_spf;
			NEXT_IP_VALID_O <= next_nip_valid;
			JUMP_TAKEN_O    <= next_jump;
			NEXT_IP_O       <= next_nip;
			CHANNEL_EN_O    <= next_chan_en;
			REG_RDATA_O     <= next_rdata;
		end
	end

endmodule : sdbx_core

//--- src/sdbx_pkg.sv
/*
 * Shared constants and types of the dot-product and conditional-branch unit.
 * Assumes one 40 MHz core clock and a synchronous active-low reset.
 */
package sdbx_pkg;

	// ------------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------------
	localparam logic [6:0]  OPC_FOUR_WIDE_DOT = 7'h54;
	localparam logic [6:0]  OPC_HOMOG_DOT     = 7'h55;
	localparam logic [6:0]  OPC_ELSE          = 7'h24;
	localparam logic [6:0]  OPC_ENDIF         = 7'h25;

	// ------------------------------------------------------------------
	// Operand fields and arithmetic constants
	// ------------------------------------------------------------------
	localparam int          JIP_W    = 16;
	localparam int          IP_STEP  = 1;
	localparam logic [31:0] FP_ONE   = 32'h3f80_0000;
	localparam logic [31:0] FP_ZERO  = 32'h0000_0000;
	localparam logic [9:0]  FP_BIAS  = 10'h07f;
	localparam logic [9:0]  FP_EMAX  = 10'h0ff;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int          REG_AW        = 4;
	localparam logic [3:0]  REG_FLOW_CTRL = 4'h0;
	localparam logic [3:0]  REG_CHAN_EN   = 4'h4;
	localparam logic [3:0]  REG_NEXT_IP   = 4'h8;
	localparam int          SPF_BIT       = 0;
	localparam logic        SPF_RESET     = 1'b0;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_DOT  = 1'b1
	} sdbx_state_t;

endpackage : sdbx_pkg

//--- src/sdbx_fma_if.sv
/*
 * Operand and result bundle between the core and its multiply-add unit.
 * Assumes a purely combinational unit on the far side.
 */
interface sdbx_fma_if;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] c;
	logic [31:0] r;

	modport core (output a, output b, output c, input r);
	modport unit (input a, input b, input c, output r);
endinterface : sdbx_fma_if

//--- src/sdbx_fma.sv
/*
 * Single-precision r = a * b + c, product rounded before the sum.
 * Assumes the caller registers the result; denormals flush to zero and
 * rounding truncates.
 */
module sdbx_fma
	import sdbx_pkg::*;
(
	sdbx_fma_if.unit bus // Operands in, sum out.
);

	// ------------------------------------------------------------------
	// Arithmetic
	// ------------------------------------------------------------------
	function automatic logic [31:0] fmul(input logic [31:0] x, input logic [31:0] y);
		logic [47:0] m;
		logic [9:0]  e;
		logic [22:0] f;
		logic        sg;
		sg = x[31] ^ y[31];
		m  = {1'b1, x[22:0]} * {1'b1, y[22:0]};
		e  = {2'b00, x[30:23]} + {2'b00, y[30:23]} - FP_BIAS;
		if (m[47]) begin
			f = m[46:24];
			e = e + 10'h001;
		end else begin
			f = m[45:23];
		end
		if (x[30:23] == 8'h00 || y[30:23] == 8'h00 || e[9] || e == 10'h000) begin
			fmul = {sg, 31'h0000_0000};
		end else if (e >= FP_EMAX) begin
			fmul = {sg, 8'hff, 23'h00_0000};
		end else begin
			fmul = {sg, e[7:0], f};
		end
	endfunction : fmul

	function automatic logic [31:0] fadd(input logic [31:0] x, input logic [31:0] y);
		logic [31:0] h;
		logic [31:0] l;
		logic [7:0]  d;
		logic [27:0] s;
		logic [27:0] ml;
		logic [9:0]  e;
		if (x[30:0] >= y[30:0]) begin
			h = x;
			l = y;
		end else begin
			h = y;
			l = x;
		end
		d  = h[30:23] - l[30:23];
		ml = {2'b01, l[22:0], 3'b000} >> d;
		if (l[30:23] == 8'h00 || d > 8'h1b) begin
			ml = 28'h000_0000;
		end
		e = {2'b00, h[30:23]};
		if (h[31] == l[31]) begin
			s = {2'b01, h[22:0], 3'b000} + ml;
		end else begin
			s = {2'b01, h[22:0], 3'b000} - ml;
		end
		if (s[27]) begin
			s = s >> 1;
			e = e + 10'h001;
		end
		for (int i = 0; i < 26; i++) begin
			if (!s[26] && s != 28'h000_0000) begin
				s = s << 1;
				e = e - 10'h001;
			end
		end
		// Both operands zero keep the sign rule of an ordinary add.
		if (h[30:23] == 8'h00) begin
			fadd = {x[31] & y[31], 31'h0000_0000};
		end else if (s == 28'h000_0000 || e[9] || e == 10'h000) begin
			fadd = FP_ZERO;
		end else if (e >= FP_EMAX) begin
			fadd = {h[31], 8'hff, 23'h00_0000};
		end else begin
			fadd = {h[31], e[7:0], s[25:3]};
		end
	endfunction : fadd

	assign bus.r = fadd(fmul(bus.a, bus.b), bus.c);

endmodule : sdbx_fma

//--- test/sdbx_core_props.sv
/* Checker on the core ports.
   Assumes a bind into every sdbx_core. */
module sdbx_core_props
	import sdbx_pkg::*;
#(
	parameter int NCH = 8, // Channels.
	parameter int IPW = 32 // Pointer width.
) (
	input wire logic                 CORE_CLK_I,      // Clock.
	input wire logic                 RESETN_I,        // Reset.
	input wire logic                 THREAD_START_I,  // Start.
	input wire logic [NCH-1:0]       DISPATCH_MASK_I, // Dispatch.
	input wire logic                 INSTR_VALID_I,   // Valid.
	input wire logic [6:0]           OPCODE_I,        // Opcode.
	input wire logic [IPW-1:0]       INSTR_IP_I,      // Pointer.
	input wire logic [$clog2(NCH):0] EXEC_SIZE_I,     // Width.
	input wire logic [31:0]          DST_FIELD_I,     // Dst field.
	input wire logic [31:0]          SRC1_FIELD_I,    // Src1 field.
	input wire logic                 BUSY_O,          // Busy.
	input wire logic                 RESULT_VALID_O,  // Result.
	input wire logic [NCH-1:0]       DST_WE_O,        // Dst writes.
	input wire logic [NCH-1:0]       ACC_WE_O,        // Acc writes.
	input wire logic [NCH*32-1:0]    DST_DATA_O,      // Data.
	input wire logic                 NEXT_IP_VALID_O, // Branch done.
	input wire logic                 JUMP_TAKEN_O,    // Jumped.
	input wire logic [IPW-1:0]       NEXT_IP_O,       // Next pointer.
	input wire logic [NCH-1:0]       CHANNEL_EN_O     // Enables.
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [IPW-1:0] ip_q;
	logic [15:0]    dfl_q;
	logic [15:0]    sfl_q;
	logic [6:0]     op_q;
	logic [NCH-1:0] live_q;
	logic           dot_go;
	logic           br_go;

	assign dot_go = INSTR_VALID_I && !BUSY_O &&
		(OPCODE_I == OPC_FOUR_WIDE_DOT || OPCODE_I == OPC_HOMOG_DOT);
	assign br_go = INSTR_VALID_I && !BUSY_O && !THREAD_START_I &&
		(OPCODE_I == OPC_ELSE || OPCODE_I == OPC_ENDIF);

	// Instruction fields are held so the answer one cycle later can be judged.
	always_ff @(posedge CORE_CLK_I) begin
		ip_q  <= INSTR_IP_I;
		dfl_q <= DST_FIELD_I[15:0];
		sfl_q <= SRC1_FIELD_I[15:0];
		op_q  <= OPCODE_I;
		if (!RESETN_I)
			live_q <= '0;
		else if (THREAD_START_I)
			live_q <= DISPATCH_MASK_I;
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);

	busy_on_dot_a: assert property (dot_go |=> BUSY_O)
		else $error("dot did not raise busy");
	dot_latency_a: assert property (dot_go && EXEC_SIZE_I == 4 |=>
		BUSY_O [*4] ##1 (RESULT_VALID_O && !BUSY_O)) else $error("dot latency wrong");
	we_with_valid_a: assert property (!RESULT_VALID_O |->
		DST_WE_O == '0 && ACC_WE_O == '0) else $error("write outside result");
	one_target_a: assert property (RESULT_VALID_O |->
		DST_WE_O == '0 || ACC_WE_O == '0) else $error("both targets written");
	group_copy_a: assert property (RESULT_VALID_O && DST_WE_O[0] && DST_WE_O[2] |->
		DST_DATA_O[31:0] == DST_DATA_O[95:64]) else $error("group not replicated");
	branch_answer_a: assert property (br_go |=> NEXT_IP_VALID_O)
		else $error("branch not answered");
	step_no_jump_a: assert property (NEXT_IP_VALID_O && !JUMP_TAKEN_O |->
		NEXT_IP_O == ip_q + IPW'(IP_STEP)) else $error("no-jump pointer wrong");
	else_target_a: assert property (NEXT_IP_VALID_O && JUMP_TAKEN_O && op_q == OPC_ELSE |->
		NEXT_IP_O == ip_q + IPW'($signed(dfl_q))) else $error("else target wrong");
	endif_target_a: assert property (NEXT_IP_VALID_O && JUMP_TAKEN_O && op_q == OPC_ENDIF |->
		NEXT_IP_O == ip_q + IPW'($signed(sfl_q))) else $error("endif target wrong");
	live_only_a: assert property ((CHANNEL_EN_O & ~live_q) == '0)
		else $error("inactive channel enabled");
endmodule : sdbx_core_props

bind sdbx_core sdbx_core_props #(.NCH(NCH), .IPW(IPW)) u_props (
	.CORE_CLK_I(CORE_CLK_I),
	.RESETN_I(RESETN_I),
	.THREAD_START_I(THREAD_START_I),
	.DISPATCH_MASK_I(DISPATCH_MASK_I),
	.INSTR_VALID_I(INSTR_VALID_I),
	.OPCODE_I(OPCODE_I),
	.INSTR_IP_I(INSTR_IP_I),
	.EXEC_SIZE_I(EXEC_SIZE_I),
	.DST_FIELD_I(DST_FIELD_I),
	.SRC1_FIELD_I(SRC1_FIELD_I),
	.BUSY_O(BUSY_O),
	.RESULT_VALID_O(RESULT_VALID_O),
	.DST_WE_O(DST_WE_O),
	.ACC_WE_O(ACC_WE_O),
	.DST_DATA_O(DST_DATA_O),
	.NEXT_IP_VALID_O(NEXT_IP_VALID_O),
	.JUMP_TAKEN_O(JUMP_TAKEN_O),
	.NEXT_IP_O(NEXT_IP_O),
	.CHANNEL_EN_O(CHANNEL_EN_O)
);

//--- test/sdbx_fetch_model.sv
/* Instruction fetch and thread control feeding the core.
   Assumes the core clock; callers wait for answers themselves. */
module sdbx_fetch_model
	import sdbx_pkg::*;
#(
	parameter int NCH = 8, // Channels.
	parameter int IPW = 32 // Pointer width.
) (
	input  wire logic            clk_i,   // Core clock.
	output logic                 start_o, // Thread start.
	output logic [NCH-1:0]       mask_o,  // Dispatch mask.
	output logic                 valid_o, // Instruction present.
	output logic [6:0]           op_o,    // Opcode.
	output logic [IPW-1:0]       ip_o,    // Pointer.
	output logic [$clog2(NCH):0] size_o,  // Width.
	output logic [31:0]          dst_o,   // Dst field.
	output logic [31:0]          src1_o,  // Src1 field.
	output logic                 acc_o,   // Acc target.
	output logic [NCH-1:0]       wmask_o, // Write mask.
	output logic [NCH*32-1:0]    s0_o,    // Source 0.
	output logic [NCH*32-1:0]    s1_o     // Source 1.
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		{start_o, mask_o, valid_o, op_o, ip_o, size_o} = '0;
		{dst_o, src1_o, acc_o, wmask_o} = '0;
		for (int n = 0; n < NCH; n++) begin
			s0_o[32*n +: 32] = 32'h4000_0000;
			s1_o[32*n +: 32] = 32'h3f80_0000;
		end
		s1_o[63:32]  = 32'h4000_0000;
		s1_o[95:64]  = 32'h4040_0000;
		s1_o[127:96] = 32'h4080_0000;
	end

	task automatic begin_thread(input logic [IPW-1:0] ip, input logic [NCH-1:0] m);
		@(posedge clk_i);
		start_o <= 1'b1;
		ip_o    <= ip;
		mask_o  <= m;
		@(posedge clk_i);
		start_o <= 1'b0;
	endtask : begin_thread

	// The field not used by else or end-if carries a decoy so a swapped field shows.
	task automatic issue(input logic [6:0] op, input logic [IPW-1:0] ip,
		input logic [$clog2(NCH):0] sz, input logic [15:0] f, input logic acc,
		input logic [NCH-1:0] wm);
		@(posedge clk_i);
		valid_o <= 1'b1;
		op_o    <= op;
		ip_o    <= ip;
		size_o  <= sz;
		dst_o   <= {16'h0, (op == OPC_ENDIF) ? 16'h0007 : f};
		src1_o  <= {16'h0, (op == OPC_ELSE) ? 16'h0007 : f};
		acc_o   <= acc;
		wmask_o <= wm;
		@(posedge clk_i);
		valid_o <= 1'b0;
	endtask : issue
endmodule : sdbx_fetch_model

//--- test/sdbx_core_tb.sv
/* Self-checking bench of the core.
   Assumes the fetch model and the bound checker. */
module sdbx_core_tb
	import sdbx_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic         clk, rst_n, rwr, rrd, start, valid, acc, busy, rv, niv, jt;
	logic [3:0]   ra, esz;
	logic [6:0]   op;
	logic [7:0]   dmask, wmask, dwe, awe, cen;
	logic [31:0]  rwd, rdat, ip, dfld, sfld, nip;
	logic [255:0] s0, s1, ddat;
	int           num_errors, checks_done, cycles;

	sdbx_fetch_model #(.NCH(8), .IPW(32)) fetch (.clk_i(clk), .start_o(start),
		.mask_o(dmask), .valid_o(valid), .op_o(op), .ip_o(ip), .size_o(esz),
		.dst_o(dfld), .src1_o(sfld), .acc_o(acc), .wmask_o(wmask), .s0_o(s0), .s1_o(s1));

	sdbx_core #(.NCH(8), .IPW(32)) dut (.CORE_CLK_I(clk), .RESETN_I(rst_n),
		.REG_ADDR_I(ra), .REG_WDATA_I(rwd), .REG_WR_I(rwr), .REG_RD_I(rrd),
		.REG_RDATA_O(rdat), .THREAD_START_I(start), .DISPATCH_MASK_I(dmask),
		.INSTR_VALID_I(valid), .OPCODE_I(op), .INSTR_IP_I(ip), .EXEC_SIZE_I(esz),
		.DST_FIELD_I(dfld), .SRC1_FIELD_I(sfld), .DST_IS_ACC_I(acc),
		.WRITE_MASK_I(wmask), .SRC0_DATA_I(s0), .SRC1_DATA_I(s1), .BUSY_O(busy),
		.RESULT_VALID_O(rv), .DST_WE_O(dwe), .ACC_WE_O(awe), .DST_DATA_O(ddat),
		.NEXT_IP_VALID_O(niv), .JUMP_TAKEN_O(jt), .NEXT_IP_O(nip), .CHANNEL_EN_O(cen));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic close_out();
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		rwr <= 1'b1;
		ra  <= a;
		rwd <= d;
		@(posedge clk);
		rwr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		rrd <= 1'b1;
		ra  <= a;
		@(posedge clk);
		rrd <= 1'b0;
		#1;
		chk(rdat, e);
	endtask : rd

	task automatic br(input logic [6:0] o, input logic [31:0] p, input logic [15:0] f,
		input logic j, input logic [31:0] nx, input logic [7:0] en);
		fetch.issue(o, p, (o == OPC_ENDIF) ? 4'h0 : 4'h8, f, 1'b0, 8'h00);
		#1;
		chk(niv, 1'b1);
		chk(jt, j);
		chk(nip, nx);
		chk(cen, en);
	endtask : br

	task automatic dot(input logic [6:0] o, input logic [3:0] e, input logic a,
		input logic [7:0] wm, input logic [7:0] we, input logic [31:0] g0,
		input logic [31:0] g1);
		int n;
		fetch.issue(o, 32'h0, e, 16'h0, a, wm);
		#1;
		chk(busy, 1'b1);
		n = 1;
		while (rv !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(32'(n), 32'(e) + 32'h1);
		chk(a ? awe : dwe, we);
		chk(a ? dwe : awe, 8'h00);
		chk(ddat[31:0], g0);
		if (e == 4'h8)
			chk(ddat[159:128], g1);
	endtask : dot

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			close_out();
		end
	end

	initial begin
		{rst_n, rwr, rrd, ra, rwd} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		fetch.begin_thread(32'h0b, 8'h0f);
		#1;
		chk(cen, 8'h0f);
		br(OPC_ELSE, 32'h0a, 16'h0005, 1'b0, 32'h0b, 8'h0f);
		br(OPC_ELSE, 32'h0b, 16'h0005, 1'b1, 32'h10, 8'h0f);
		br(OPC_ENDIF, 32'h10, 16'h0003, 1'b0, 32'h11, 8'h0f);
		br(OPC_ENDIF, 32'h1e, 16'hfffc, 1'b1, 32'h1a, 8'h00);
		wr(REG_FLOW_CTRL, 32'h1);
		rd(REG_FLOW_CTRL, 32'h1);
		rd(REG_CHAN_EN, 32'h0);
		rd(REG_NEXT_IP, 32'h1a);
		rd(4'hc, 32'h0);
		br(OPC_ELSE, 32'h28, 16'h0002, 1'b1, 32'h2a, 8'h0f);
		wr(REG_FLOW_CTRL, 32'h0);
		br(OPC_ENDIF, 32'h11, 16'h0003, 1'b0, 32'h12, 8'h0f);
		dot(OPC_FOUR_WIDE_DOT, 4'h8, 1'b0, 8'hb5, 8'hb5, 32'h41a0_0000, 32'h4100_0000);
		dot(OPC_HOMOG_DOT, 4'h8, 1'b1, 8'hff, 8'hff, 32'h4180_0000, 32'h40e0_0000);
		dot(OPC_FOUR_WIDE_DOT, 4'h4, 1'b0, 8'hff, 8'h0f, 32'h41a0_0000, 32'h0);
		close_out();
	end
endmodule : sdbx_core_tb
